// file: acq_pkg.sv
package acq_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 100;
  localparam logic [63:0] TS_STEP       = 64'(CLK_PERIOD_NS);
  localparam int          READOUT_NS    = 5000;
  localparam logic [31:0] READOUT_CYC   =
    32'((READOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          NOTREADY_NS   = 2000;
  localparam logic [15:0] NOTREADY_CYC  =
    16'((NOTREADY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_EXPOSE  = 8'h08;
  localparam logic [7:0] REG_EVT_EN  = 8'h0C;
  localparam logic [7:0] REG_TS_LO   = 8'h10;
  localparam logic [7:0] REG_TS_HI   = 8'h14;
  localparam logic [7:0] REG_FRAME   = 8'h18;
  localparam logic [7:0] REG_OFFSET  = 8'h1C;
  localparam logic [7:0] REG_SIZE    = 8'h20;
  localparam logic [7:0] REG_FORMAT  = 8'h24;
  localparam logic [7:0] REG_GAIN    = 8'h28;
  localparam logic [7:0] REG_BINNING = 8'h2C;
  localparam logic [7:0] REG_BLACK   = 8'h30;

  // ----------------------------------------------------------------------
  // Control bit positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_ABORT  = 2;
  localparam int CTRL_TRIG   = 3;
  localparam int CTRL_CHUNK  = 4;
  localparam int CTRL_IF_ON  = 5;
  localparam int CTRL_SWTRIG = 6;
  localparam logic [31:0] EXPOSE_RST = 32'h0000000A;
  localparam logic [31:0] PARAM_RST  = 32'h00000000;
  localparam logic [14:0] EVT_EN_RST = 15'h0000;

  // ----------------------------------------------------------------------
  // Event identifiers
  // ----------------------------------------------------------------------
  localparam int NUM_EVT = 15;
  localparam logic [3:0] EV_EXP_BEGAN  = 4'h0;
  localparam logic [3:0] EV_EXP_DONE   = 4'h1;
  localparam logic [3:0] EV_FRAME_BEG  = 4'h2;
  localparam logic [3:0] EV_FRAME_FIN  = 4'h3;
  localparam logic [3:0] EV_RISE0      = 4'h4;
  localparam logic [3:0] EV_FALL0      = 4'h8;
  localparam logic [3:0] EV_DROPPED    = 4'hC;
  localparam logic [3:0] EV_UNPROC     = 4'hD;
  localparam logic [3:0] EV_TRIG_READY = 4'hE;

  // Words sent per image: time mark and frame number, then info block
  localparam logic [3:0] HDR_WORDS   = 4'h3;
  localparam logic [3:0] CHUNK_WORDS = 4'hB;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PARAM, ST_WAIT_TRIG, ST_EXPOSE, ST_READOUT, ST_TRANSMIT
  } acq_state_e;

endpackage

// file: pin_sync.sv
module pin_sync
  import acq_pkg::*;
#(
  parameter int N = 5
)(
  input  wire logic         CLK_SYS,
  input  wire logic         ARST_N,
  input  wire logic [N-1:0] PIN,
  output logic      [N-1:0] LEVEL
);

  typedef struct packed {
    logic [N-1:0] f1;
    logic [N-1:0] f2;
    logic [N-1:0] f3;
    logic [N-1:0] q;
  } sync_s;

  sync_s r;
  sync_s n;

  // Fourth stage filters: a bit rises only when stages two and three are both high, and drops as soon as they differ
  always_comb
  begin
    n    = r;
    n.f1 = PIN;
    n.f2 = r.f1;
    n.f3 = r.f2;
    n.q  = (r.f2 & r.f3) | (r.q & ~(r.f2 ^ r.f3));
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      r <= '0;
    else
      r <= n;
  end

  assign LEVEL = r.q;

endmodule // pin_sync

// file: acq_core.sv
// Operation
// R1 - Keep a free-running 64-bit timestamp counting nanoseconds.
// R2 - Every transmitted image carries its own timestamp.
// R3 - Timestamp restarts from zero at power-up or reset, then counts up.
// R4 - No software function can clear the timestamp.
// R5 - With chunk mode on, append an info block to every image payload.
// R6 - Info block time field holds the count sampled at frame begin.
// R7 - Info block holds offsets, size, format, exposure, gain, id, binning, etc.
// R8 - Each message-channel event carries a 64-bit timestamp of its occurrence.
// R9 - Each event type has its own host-set enable; disabled ones stay silent.
// R10 - Raise events at exposure start and end, frame start and end.
// R11 - Separate rise and fall events for each of IO lines 0 to 3.
// R12 - Raise events for a discarded event and an unprocessed event.
// R13 - Raise a trigger-ready event once the not-ready interval elapses.
// R14 - Started acquisition loops: select parameters, expose, read out, until stopped.
// R15 - Stop during readout finishes that readout before stopping.
// R16 - Stop during exposure aborts the exposure.
// R17 - Abort ends a running exposure at once and skips its readout.
// R18 - Images are sent only after the interface is started; else dropped.
// R19 - Stopping the interface aborts an ongoing transmission immediately.
// R20 - Free-running mode acquires back to back with no external event.
// R21 - Trigger mode starts each capture only on an external trigger; the code also starts one on the CTRL_SWTRIG software trigger bit.
// R22 - Timestamp advances each clock by the clock period in nanoseconds.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
module acq_core
  import acq_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [3:0]  IO_LINE,
  input  wire logic        TRIG_IN,
  input  wire logic [15:0] TEMP_IN,
  output logic             TX_VALID,
  output logic      [31:0] TX_DATA,
  output logic             TX_LAST,
  input  wire logic        TX_READY,
  output logic             EVT_VALID,
  output logic      [3:0]  EVT_ID,
  output logic      [63:0] EVT_TS,
  input  wire logic        EVT_READY
);

  typedef struct packed {
    logic [63:0]         ts;
    acq_state_e          state;
    logic                ack;
    logic [31:0]         dat;
    logic                trig_mode;
    logic                chunk_en;
    logic                if_on;
    logic [31:0]         expose;
    logic [14:0]         evt_en;
    logic [31:0]         p_off;
    logic [31:0]         p_size;
    logic [31:0]         p_fmt;
    logic [31:0]         p_gain;
    logic [31:0]         p_bin;
    logic [31:0]         p_black;
    logic [31:0]         s_off;
    logic [31:0]         s_size;
    logic [31:0]         s_fmt;
    logic [31:0]         s_gain;
    logic [31:0]         s_bin;
    logic [31:0]         s_black;
    logic [31:0]         s_exp;
    logic [15:0]         s_temp;
    logic                s_chunk;
    logic                s_trig;
    logic [31:0]         frame_id;
    logic [63:0]         frame_ts;
    logic [31:0]         cnt;
    logic [15:0]         trig_cnt;
    logic                stop_pend;
    logic [4:0]          pins_prev;
    logic                tx_valid;
    logic [31:0]         tx_data;
    logic                tx_last;
    logic [3:0]          tx_idx;
    logic                evt_valid;
    logic [3:0]          evt_id;
    logic [63:0]         evt_ts;
    logic                drop_pend;
    logic [63:0]         drop_ts;
    logic                lost_pend;
    logic [63:0]         lost_ts;
  } core_s;

  core_s       r;
  core_s       n;
  logic [4:0]  pins;
  logic [14:0] ev;
  logic        start_p;
  logic        stop_p;
  logic        abort_p;
  logic        trig_go;

  // ----------------------------------------------------------------------
  // Pin synchronisers for trigger and IO lines
  // ----------------------------------------------------------------------
  pin_sync #(.N(5)) u_sync (
    .CLK_SYS (CLK_SYS),
    .ARST_N  (ARST_N),
    .PIN     ({TRIG_IN, IO_LINE}),
    .LEVEL   (pins)
  );

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  // Payload word by index: header first, info block after it
  function automatic logic [31:0] word_at(input core_s s,
                                          input logic [3:0] idx);
    case (idx)
      4'h0:    return s.frame_ts[31:0];
      4'h1:    return s.frame_ts[63:32];
      4'h2:    return s.frame_id;
      4'h3:    return s.s_off;
      4'h4:    return s.s_size;
      4'h5:    return s.s_fmt;
      4'h6:    return s.s_exp;
      4'h7:    return s.s_gain;
      4'h8:    return s.s_bin;
      4'h9:    return s.s_black;
      4'hA:    return {16'h0000, s.s_temp};
      4'hB:    return s.frame_ts[31:0];
      4'hC:    return s.frame_ts[63:32];
      default: return s.frame_id;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic        hit;
    logic        wr;
    logic [7:0]  adr;
    logic        go_exp;
    logic        go_next;
    logic [14:0] m;
    logic        free;
    logic        dropped;
    logic [3:0]  last;
    hit     = WB_CYC_I & WB_STB_I;
    wr      = hit & r.ack & WB_WE_I;
    adr     = {WB_ADR_I[7:2], 2'b00};
    go_exp  = 1'b0;
    go_next = 1'b0;
    dropped = 1'b0;
    m       = '0;
    free    = 1'b0;
    last    = 4'h0;
    ev      = '0;
    n       = r;
    // R22 advance by period
    // R1 nanosecond count, no write path
    n.ts    = r.ts + TS_STEP;

    // Bus slave: ack one cycle after the request, write at the ack edge
    n.ack   = hit & ~r.ack;
    start_p = wr && adr == REG_CTRL && WB_SEL_I[0] && WB_DAT_I[CTRL_START];
    stop_p  = wr && adr == REG_CTRL && WB_SEL_I[0] && WB_DAT_I[CTRL_STOP];
    abort_p = wr && adr == REG_CTRL && WB_SEL_I[0] && WB_DAT_I[CTRL_ABORT];
    trig_go = (pins[4] & ~r.pins_prev[4]) | (wr && adr == REG_CTRL &&
              WB_SEL_I[0] && WB_DAT_I[CTRL_SWTRIG]);
    if (hit & ~r.ack)
    begin
      if (adr == REG_CTRL)
        n.dat = {26'h0, r.if_on, r.chunk_en, r.trig_mode, 3'h0};
      else if (adr == REG_STATUS)
        n.dat = {24'h0, (r.trig_cnt == 16'h0), r.stop_pend, r.if_on,
                 2'b00, r.state};
      else if (adr == REG_EXPOSE)
        n.dat = r.expose;
      else if (adr == REG_EVT_EN)
        n.dat = {17'h0, r.evt_en};
      else if (adr == REG_TS_LO)
        n.dat = r.ts[31:0];
      else if (adr == REG_TS_HI)
        n.dat = r.ts[63:32];
      else if (adr == REG_FRAME)
        n.dat = r.frame_id;
      else if (adr == REG_OFFSET)
        n.dat = r.p_off;
      else if (adr == REG_SIZE)
        n.dat = r.p_size;
      else if (adr == REG_FORMAT)
        n.dat = r.p_fmt;
      else if (adr == REG_GAIN)
        n.dat = r.p_gain;
      else if (adr == REG_BINNING)
        n.dat = r.p_bin;
      else if (adr == REG_BLACK)
        n.dat = r.p_black;
      else
        n.dat = '0;
    end
    // R4 timestamp words are read-only
    if (wr)
    begin
      if (adr == REG_CTRL && WB_SEL_I[0])
      begin
        n.trig_mode = WB_DAT_I[CTRL_TRIG];
        n.chunk_en  = WB_DAT_I[CTRL_CHUNK];
        n.if_on     = WB_DAT_I[CTRL_IF_ON];
      end
      else if (adr == REG_EXPOSE)
        n.expose = merge(r.expose, WB_DAT_I, WB_SEL_I);
      else if (adr == REG_EVT_EN)
        n.evt_en = 15'(merge({17'h0, r.evt_en}, WB_DAT_I, WB_SEL_I));
      else if (adr == REG_OFFSET)
        n.p_off = merge(r.p_off, WB_DAT_I, WB_SEL_I);
      else if (adr == REG_SIZE)
        n.p_size = merge(r.p_size, WB_DAT_I, WB_SEL_I);
      else if (adr == REG_FORMAT)
        n.p_fmt = merge(r.p_fmt, WB_DAT_I, WB_SEL_I);
      else if (adr == REG_GAIN)
        n.p_gain = merge(r.p_gain, WB_DAT_I, WB_SEL_I);
      else if (adr == REG_BINNING)
        n.p_bin = merge(r.p_bin, WB_DAT_I, WB_SEL_I);
      else if (adr == REG_BLACK)
        n.p_black = merge(r.p_black, WB_DAT_I, WB_SEL_I);
    end

    // R11 edge events per IO line
    n.pins_prev          = pins;
    ev[EV_RISE0 +: 4]    = pins[3:0] & ~r.pins_prev[3:0];
    ev[EV_FALL0 +: 4]    = ~pins[3:0] & r.pins_prev[3:0];

    // R13 not-ready interval countdown
    if (r.trig_cnt != 16'h0)
    begin
      n.trig_cnt = r.trig_cnt - 16'h1;
      ev[EV_TRIG_READY] = (r.trig_cnt == 16'h1);
    end

    // Acquisition loop
    case (r.state)
      ST_IDLE:
      begin
        n.stop_pend = 1'b0;
        if (start_p)
          n.state = ST_PARAM;
      end
      // R14 latch the parameter set for this image
      ST_PARAM:
      begin
        n.s_off   = r.p_off;
        n.s_size  = r.p_size;
        n.s_fmt   = r.p_fmt;
        n.s_gain  = r.p_gain;
        n.s_bin   = r.p_bin;
        n.s_black = r.p_black;
        n.s_exp   = r.expose;
        n.s_temp  = TEMP_IN;
        n.s_chunk = r.chunk_en;
        n.s_trig  = r.trig_mode;
        if (stop_p | abort_p)
          n.state = ST_IDLE;
        else if (r.trig_mode)
          n.state = ST_WAIT_TRIG;
        else
          go_exp = 1'b1; // R20 no wait when free-running
      end
      // R21 capture only on a trigger once ready again
      ST_WAIT_TRIG:
      begin
        if (stop_p | abort_p)
          n.state = ST_IDLE;
        else if (trig_go && r.trig_cnt == 16'h0)
          go_exp = 1'b1;
      end
      ST_EXPOSE:
      begin
        // R16 stop aborts exposure
        // R17 abort skips readout
        if (stop_p | abort_p)
          n.state = ST_IDLE;
        else if (r.cnt <= 32'h1)
        begin
          ev[EV_EXP_DONE] = 1'b1;
          n.state = ST_READOUT;
          n.cnt   = READOUT_CYC;
        end
        else
          n.cnt = r.cnt - 32'h1;
      end
      ST_READOUT:
      begin
        // R15 a stop only marks the loop to end after readout
        if (stop_p)
          n.stop_pend = 1'b1;
        if (abort_p)
          n.state = ST_IDLE;
        else if (r.cnt <= 32'h1)
        begin
          ev[EV_FRAME_FIN] = 1'b1;
          // R18 image dropped if interface not started
          if (r.if_on)
          begin
            n.state    = ST_TRANSMIT;
            n.tx_idx   = 4'h0;
            n.tx_valid = 1'b1;
            n.tx_data  = word_at(r, 4'h0);
            n.tx_last  = 1'b0;
          end
          else
            go_next = 1'b1;
        end
        else
          n.cnt = r.cnt - 32'h1;
      end
      ST_TRANSMIT:
      begin
        if (stop_p)
          n.stop_pend = 1'b1;
        // R5 info block length set by chunk mode
        last = r.s_chunk ? HDR_WORDS + CHUNK_WORDS - 4'h1 : HDR_WORDS - 4'h1;
        // R19 interface stop cuts the transfer
        if (!r.if_on | abort_p)
        begin
          n.tx_valid = 1'b0;
          n.tx_last  = 1'b0;
          if (abort_p)
            n.state = ST_IDLE;
          else
            go_next = 1'b1;
        end
        else if (r.tx_valid & TX_READY)
        begin
          if (r.tx_last)
          begin
            n.tx_valid = 1'b0;
            n.tx_last  = 1'b0;
            go_next    = 1'b1;
          end
          else
          begin
            // R2 header words carry the image time
            // R7 info block fields
            n.tx_idx  = r.tx_idx + 4'h1;
            n.tx_data = word_at(r, r.tx_idx + 4'h1);
            n.tx_last = (r.tx_idx + 4'h1) == last;
          end
        end
      end
      default:
        n.state = ST_IDLE;
    endcase

    // R14 repeat until stopped
    if (go_next)
      n.state = (r.stop_pend | stop_p) ? ST_IDLE : ST_PARAM;
    // R10 exposure and frame begin share one instant
    // R6 sample the time mark at frame begin
    if (go_exp)
    begin
      n.state    = ST_EXPOSE;
      // Take the set latched in this same cycle, so a fresh exposure
      // value applies to the very image that latched it
      n.cnt      = (n.s_exp == 32'h0) ? 32'h1 : n.s_exp;
      n.frame_ts = r.ts;
      n.frame_id = r.frame_id + 32'h1;
      ev[EV_EXP_BEGAN] = 1'b1;
      ev[EV_FRAME_BEG] = 1'b1;
      if (n.s_trig)
        n.trig_cnt = NOTREADY_CYC;
    end

    // R9 only enabled events leave the block
    // R8 new events stamped with the current time, drop and unprocessed notices with their saved time
    m    = ev & r.evt_en;
    free = ~r.evt_valid | EVT_READY;
    if (free)
      n.evt_valid = 1'b0;
    if (m != 15'h0)
    begin
      dropped = ~free | ((m & (m - 15'h1)) != 15'h0);
      if (free)
      begin
        n.evt_valid = 1'b1;
        n.evt_ts    = r.ts;
        for (int i = NUM_EVT - 1; i >= 0; i--)
        begin
          if (m[i])
            n.evt_id = 4'(i);
        end
      end
    end
    else if (free & r.drop_pend)
    begin
      n.evt_valid = 1'b1;
      n.evt_id    = EV_DROPPED;
      n.evt_ts    = r.drop_ts;
      n.drop_pend = 1'b0;
    end
    else if (free & r.lost_pend)
    begin
      n.evt_valid = 1'b1;
      n.evt_id    = EV_UNPROC;
      n.evt_ts    = r.lost_ts;
      n.lost_pend = 1'b0;
    end
    // R12 overflow of the notice slot becomes a dropped notice, a further one while it is pending an unprocessed notice
    if (dropped && r.evt_en[EV_DROPPED])
    begin
      if (!r.drop_pend)
      begin
        n.drop_pend = 1'b1;
        n.drop_ts   = r.ts;
      end
      else if (r.evt_en[EV_UNPROC] && !r.lost_pend)
      begin
        n.lost_pend = 1'b1;
        n.lost_ts   = r.ts;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // R3 reset returns the time mark to zero
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r         <= '0;
      r.state   <= ST_IDLE;
      r.expose  <= EXPOSE_RST;
      r.evt_en  <= EVT_EN_RST;
      r.p_off   <= PARAM_RST;
    end
    else
      r <= n;
  end

  assign WB_DAT_O  = r.dat;
  assign WB_ACK_O  = r.ack;
  assign TX_VALID  = r.tx_valid;
  assign TX_DATA   = r.tx_data;
  assign TX_LAST   = r.tx_last;
  assign EVT_VALID = r.evt_valid;
  assign EVT_ID    = r.evt_id;
  assign EVT_TS    = r.evt_ts;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  AST_TS_STEP: assert property ( // R22
    ARST_N |=> r.ts == $past(r.ts) + TS_STEP)
    else $error("timestamp did not advance by one period");
  AST_EVT_EN: assert property ( // R9
    EVT_VALID && (!$past(EVT_VALID) || $past(EVT_READY)) |->
    (($past(r.evt_en) >> EVT_ID) & 15'h1) != 15'h0)
    else $error("disabled event was signalled");
  AST_EXP_ABORT: assert property ( // R17
    r.state == ST_EXPOSE && abort_p |=> r.state == ST_IDLE)
    else $error("abort did not end exposure");
  AST_STOP_RD: assert property ( // R15
    r.state == ST_READOUT && stop_p && !abort_p && r.cnt > 32'h1
    |=> r.state == ST_READOUT && r.stop_pend)
    else $error("stop cut a readout short");
  AST_FRAME_TS: assert property ( // R6
    ev[EV_FRAME_BEG] |=> r.frame_ts == $past(r.ts) && $rose(r.state == ST_EXPOSE))
    else $error("frame time mark not sampled at frame begin");
  AST_TX_IF: assert property ( // R19
    !r.if_on |=> !TX_VALID)
    else $error("transfer continued with interface stopped");
  AST_FREE_RUN: assert property ( // R20
    r.state == ST_PARAM && !r.trig_mode && !stop_p && !abort_p
    |=> r.state == ST_EXPOSE)
    else $error("free-running loop waited");
  AST_TRIG_HOLD: assert property ( // R21
    r.state == ST_WAIT_TRIG && !trig_go && !stop_p && !abort_p
    |=> r.state == ST_WAIT_TRIG)
    else $error("capture started without a trigger");
  AST_CHUNK: assert property ( // R5
    TX_VALID && TX_LAST |-> r.tx_idx == (r.s_chunk ? 4'hD : 4'h2))
    else $error("payload length wrong for chunk mode");
  AST_ACK: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

endmodule // acq_core

// file: host_sink.sv
module host_sink
  import acq_pkg::*;
(
  input  wire logic CLK_SYS,
  input  wire logic ARST_N,
  output logic      TX_READY,
  output logic      EVT_READY
);
  logic [7:0] lfsr_r;

  // Stall pattern; stalls force the core to hold words and events
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      lfsr_r <= 8'hA5;
    end
    else
    begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
  end

  // Ready levels do not depend on valid, as a plain host sink
  assign TX_READY  = lfsr_r[0] | lfsr_r[1];
  assign EVT_READY = lfsr_r[2] | lfsr_r[6];
endmodule // host_sink

// file: acquisition_timestamp_events_tb_top.sv
module acquisition_timestamp_events_tb_top;
  import acq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, trig = 0;
  logic        ack, txv, txl, txr, evv, evr;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  io = 4'h0, evid;
  logic [15:0] temp = 16'h0000;
  logic [31:0] wdat = 32'h0, rd, dato, txd, seed = 32'h2E3A7B1E;
  logic [63:0] evts, ets[15];
  logic [31:0] txq[$];
  int          lastq[$];
  int          errors = 0, tests_run = 0, cnt[15] = '{default: 0};
  localparam logic [7:0] PADR[7] = '{REG_OFFSET, REG_SIZE, REG_FORMAT,
    REG_EXPOSE, REG_GAIN, REG_BINNING, REG_BLACK};

  acq_core dut (.CLK_SYS(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .IO_LINE(io),
    .TRIG_IN(trig), .TEMP_IN(temp), .TX_VALID(txv), .TX_DATA(txd),
    .TX_LAST(txl), .TX_READY(txr), .EVT_VALID(evv), .EVT_ID(evid),
    .EVT_TS(evts), .EVT_READY(evr));
  host_sink host (.CLK_SYS(clk), .ARST_N(arst_n), .TX_READY(txr),
    .EVT_READY(evr));

  // ----------------------------------------------------------------
  // Clock, monitors and helpers
  // ----------------------------------------------------------------
  // 10 MHz clock
  always #50 clk = ~clk;

  // Collect accepted payload words and events
  always @(posedge clk)
  begin
    if (txv && txr)
    begin
      txq.push_back(txd);
      if (txl) lastq.push_back(txq.size());
    end
    if (evv && evr)
    begin
      cnt[evid]++;
      ets[evid] = evts;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk(ack, 1);
  endtask

  task automatic wait_img(input int k);
    int n;
    n = 0;
    while (lastq.size() < k && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk(lastq.size() >= k, 1);
  endtask

  // Poll the state field until it shows s, or give up
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      wb(0, REG_STATUS, 0);
      n++;
    end
    while (rd[2:0] !== s && n < 100);
    chk(rd[2:0], s);
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the expected few thousand cycles
  initial
  begin
    #5000000;
    chk(64'h0, 64'h1);
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] a, b, v[7];
    int          k;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    seed = lfsr(seed);
    temp <= seed[15:0];
    wb(0, REG_TS_LO, 0);
    a = rd;
    chk(a % 100, 0);
    chk(a < 1000, 1);
    wb(0, REG_TS_LO, 0);
    b = rd;
    chk(b - a, 300);
    wb(1, REG_TS_LO, 0);
    wb(0, REG_TS_LO, 0);
    chk(rd - b, 600);
    $display("done: timestamp");
    for (int i = 0; i < 7; i++)
    begin
      seed = lfsr(seed);
      v[i] = (i == 3) ? 32'h3 : {24'h0, seed[7:0]};
      wb(1, PADR[i], v[i]);
      wb(0, PADR[i], 0);
      chk(rd, v[i]);
    end
    wb(0, 8'h40, 0);
    chk(rd, 0);
    $display("done: registers");
    wb(1, REG_EVT_EN, 32'h7FFB);
    wb(1, REG_CTRL, 32'h31);
    wait_img(2);
    for (int i = 0; i < 7; i++) chk(txq[3+i], v[i]);
    chk(txq[10], {16'h0, temp});
    chk({txq[12], txq[11]}, {txq[1], txq[0]});
    chk(txq[13], txq[2]);
    chk(lastq[0], 14);
    chk(lastq[1], 28);
    chk(txq[16] - txq[2], 1);
    chk({txq[15], txq[14]} > {txq[1], txq[0]}, 1);
    chk(ets[0], {txq[15], txq[14]});
    // Stop lands inside a readout: that image must still go out
    wait_st(3'h4);
    k = lastq.size();
    wb(1, REG_CTRL, 32'h32);
    wait_st(3'h0);
    chk(lastq.size(), k + 1);
    chk(txq.size(), 14 * lastq.size());
    chk(cnt[2], 0);
    chk(cnt[1] > 0 && cnt[3] > 0, 1);
    $display("done: free run");
    wb(1, REG_CTRL, 32'h31);
    k = 0;
    while (txv !== 1'b1 && k < 500)
    begin
      @(posedge clk);
      k++;
    end
    chk(txv, 1);
    wb(1, REG_CTRL, 32'h11);
    repeat (2) @(posedge clk);
    chk(txv, 0);
    k = txq.size();
    repeat (300) @(posedge clk);
    chk(txq.size(), k);
    // Long exposure so that the abort surely lands inside it
    wb(1, REG_EXPOSE, 32'hC8);
    wait_st(3'h4);
    wait_st(3'h3);
    wb(1, REG_CTRL, 32'h14);
    wb(0, REG_STATUS, 0);
    chk(rd[2:0], 3'h0);
    $display("done: interface and abort");
    wb(1, REG_CTRL, 32'h39);
    repeat (100) @(posedge clk);
    chk(txq.size(), k);
    wb(0, REG_STATUS, 0);
    chk(rd[2:0], 3'h2);
    cnt[14] = 0;
    k = lastq.size();
    trig <= 1'b1;
    repeat (3) @(posedge clk);
    trig <= 1'b0;
    wait_img(k + 1);
    chk(cnt[14] > 0, 1);
    // Software trigger starts the next capture as well
    wait_st(3'h2);
    wb(1, REG_CTRL, 32'h78);
    wait_img(k + 2);
    wb(1, REG_CTRL, 32'h04);
    wait_st(3'h0);
    $display("done: trigger");
    repeat (20) @(posedge clk);
    cnt = '{default: 0};
    for (int i = 0; i < 4; i++)
    begin
      io[i] <= 1'b1;
      repeat (10) @(posedge clk);
      io[i] <= 1'b0;
      repeat (10) @(posedge clk);
      chk({cnt[4+i], cnt[8+i]}, {32'd1, 32'd1});
    end
    io <= 4'hC;
    repeat (20) @(posedge clk);
    chk(cnt[12], 1);
    $display("done: io lines");
    finish_test();
  end
endmodule // acquisition_timestamp_events_tb_top
